// ---- pkg/dpl_pkg.sv ----
package dpl_pkg;

  // ==========================================================================
  // Geometry
  localparam int DPL_LANES   = 4;
  localparam int DPL_LANE_W  = 8;
  localparam int DPL_PORT_W  = 32;
  localparam int DPL_ADDR_W  = 8;
  localparam int DPL_RES_W   = 16;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] DPL_REG_CTRL     = 8'h00;
  localparam logic [7:0] DPL_REG_DRIVE    = 8'h04;
  localparam logic [7:0] DPL_REG_OUT      = 8'h08;
  localparam logic [7:0] DPL_REG_IN       = 8'h0C;
  localparam logic [7:0] DPL_REG_STATUS   = 8'h10;
  localparam logic [7:0] DPL_REG_IRQ_STAT = 8'h14;
  localparam logic [7:0] DPL_REG_IRQ_MASK = 8'h18;

  // ==========================================================================
  // Field positions
  localparam int DPL_CTRL_SRC_LSB   = 0;
  localparam int DPL_CTRL_CLK_BIT   = 2;
  localparam int DPL_STAT_LIVE_BIT  = 0;
  localparam int DPL_STAT_STICKY_BIT = 1;
  localparam int DPL_IRQ_W          = 2;
  localparam int DPL_IRQ_OVF_BIT    = 0;
  localparam int DPL_IRQ_IN_BIT     = 1;
  localparam int DPL_RES_LSB        = 0;
  localparam int DPL_RES_STB_BIT    = 16;
  localparam int DPL_ALT_STB_BIT    = 0;
  localparam int DPL_ALT_LSB        = 1;
  localparam int DPL_ALT_W          = 10;

  // ==========================================================================
  // Reset values
  localparam logic [3:0]  DPL_DRIVE_RST = 4'h0;
  localparam logic [31:0] DPL_OUT_RST   = 32'h0000_0000;
  localparam logic [1:0]  DPL_MASK_RST  = 2'h0;

  // ==========================================================================
  // Timing
  localparam int DPL_SYS_CLK_KHZ = 50000;
  localparam int DPL_INT_CLK_KHZ = 56250;
  localparam int DPL_INT_DIV     = (DPL_SYS_CLK_KHZ >= DPL_INT_CLK_KHZ) ?
                                   DPL_SYS_CLK_KHZ / DPL_INT_CLK_KHZ : 1;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    DPL_SRC_MANUAL = 2'b00,
    DPL_SRC_SEQ    = 2'b01,
    DPL_SRC_RES    = 2'b10,
    DPL_SRC_ALT    = 2'b11
  } dpl_src_t;

  typedef struct packed {
    logic     clk_ext;
    dpl_src_t src;
  } dpl_ctrl_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } dpl_word_t;

  typedef struct packed {
    logic                 valid;
    logic [DPL_RES_W-1:0] data;
  } dpl_res_t;

  localparam dpl_ctrl_t DPL_CTRL_RST = '{clk_ext: 1'b0, src: DPL_SRC_MANUAL};

endpackage

// ---- rtl/dpl_sync.sv ----
`timescale 1ns/1ns
module dpl_sync import dpl_pkg::*; #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  // ==========================================================================
  // Two-stage synchroniser; the first stage feeds only the second.
  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end

endmodule

// ---- rtl/dpl_fmt.sv ----
`timescale 1ns/1ns
module dpl_fmt import dpl_pkg::*; (
  input  wire logic                 alt,
  input  wire logic [DPL_RES_W-1:0] res,
  input  wire logic                 stb,
  output logic      [DPL_PORT_W-1:0] word
);

  // ==========================================================================
  // The strobe toggles once per result so that equal results stay visible.
  always_comb begin
    word = '0;
    if (alt) begin
      word[DPL_ALT_LSB +: DPL_ALT_W] = res[DPL_ALT_W-1:0];
      word[DPL_ALT_STB_BIT]          = stb;
    end else begin
      word[DPL_RES_LSB +: DPL_RES_W] = res;
      word[DPL_RES_STB_BIT]          = stb;
    end
  end

endmodule

// ---- rtl/dpl_port_ctrl.sv ----
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ns
module dpl_port_ctrl import dpl_pkg::*; #(
  parameter int LANES  = DPL_LANES,
  parameter int LANE_W = DPL_LANE_W
) (
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic [DPL_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [31:0]           reg_rdata,
  input  wire dpl_word_t             seq_cmd,
  input  wire dpl_res_t              res_in,
  input  wire logic [DPL_PORT_W-1:0] port_in,
  input  wire logic                  port_ext_clk,
  output logic      [DPL_PORT_W-1:0] port_out,
  output logic      [DPL_PORT_W-1:0] port_oe,
  output logic                       irq
);

  // ==========================================================================
  // Decoding
  function automatic logic reg_hit(input logic [DPL_ADDR_W-1:0] a,
                                   input logic [7:0]            off);
    reg_hit = (a == off);
  endfunction

  // Both result formats share the holder, the strobe and the overflow logic.
  function automatic logic result_src(input dpl_src_t s);
    result_src = (s == DPL_SRC_RES) || (s == DPL_SRC_ALT);
  endfunction

  logic wr_ctrl;
  logic wr_drive;
  logic wr_out;
  logic wr_status;
  logic wr_mask;
  logic rd_irq_stat;

  always_comb begin
    wr_ctrl     = reg_wr && reg_hit(reg_addr, DPL_REG_CTRL);
    wr_drive    = reg_wr && reg_hit(reg_addr, DPL_REG_DRIVE);
    wr_out      = reg_wr && reg_hit(reg_addr, DPL_REG_OUT);
    wr_status   = reg_wr && reg_hit(reg_addr, DPL_REG_STATUS);
    wr_mask     = reg_wr && reg_hit(reg_addr, DPL_REG_IRQ_MASK);
    rd_irq_stat = reg_rd && reg_hit(reg_addr, DPL_REG_IRQ_STAT);
  end

  // ==========================================================================
  // Pin synchronisation
  // Every port pin and the clock pin pass two flops before any logic reads them.
  logic [DPL_PORT_W-1:0] in_s;
  logic                  ext_clk_s;

  dpl_sync #(
    .W (DPL_PORT_W + 1)
  ) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     ({port_ext_clk, port_in}),
    .q     ({ext_clk_s, in_s})
  );

  // ==========================================================================
  // Control registers
  dpl_ctrl_t             ctrl_r;
  dpl_ctrl_t             ctrl_nxt;
  logic [LANES-1:0]      drive_r;
  logic [LANES-1:0]      drive_nxt;
  logic [DPL_PORT_W-1:0] out_val_r;
  logic [DPL_PORT_W-1:0] out_val_nxt;
  logic [DPL_IRQ_W-1:0]  mask_r;
  logic [DPL_IRQ_W-1:0]  mask_nxt;

  // Writes to read-only or unmapped offsets match no strobe and are dropped.

  always_comb begin
    ctrl_nxt    = ctrl_r;
    drive_nxt   = drive_r;
    out_val_nxt = out_val_r;
    mask_nxt    = mask_r;
    if (wr_ctrl) begin
      ctrl_nxt.src     = dpl_src_t'(reg_wdata[DPL_CTRL_SRC_LSB +: 2]);
      ctrl_nxt.clk_ext = reg_wdata[DPL_CTRL_CLK_BIT];
    end
    if (wr_drive) begin
      drive_nxt = reg_wdata[LANES-1:0];
    end
    if (wr_out) begin
      out_val_nxt = reg_wdata;
    end
    if (wr_mask) begin
      mask_nxt = reg_wdata[DPL_IRQ_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_r    <= DPL_CTRL_RST;
      drive_r   <= DPL_DRIVE_RST;
      out_val_r <= DPL_OUT_RST;
      mask_r    <= DPL_MASK_RST;
    end else begin
      ctrl_r    <= ctrl_nxt;
      drive_r   <= drive_nxt;
      out_val_r <= out_val_nxt;
      mask_r    <= mask_nxt;
    end
  end

  // ==========================================================================
  // Port tick
  // The system clock is slower than the internal port rate, so the internal
  // tick saturates at one per cycle; the port then runs at the system rate.
  // An external clock is sampled, so it must stay high and low for two system
  // cycles each; a faster external clock loses edges.
  logic [7:0] div_r;
  logic [7:0] div_nxt;
  logic       ext_prev_r;
  logic       ext_prev_nxt;
  logic       int_tick;
  logic       tick;

  always_comb begin
    int_tick     = (div_r == 8'(DPL_INT_DIV - 1));
    div_nxt      = int_tick ? 8'h00 : div_r + 8'h01;
    ext_prev_nxt = ext_clk_s;
    // An external rising edge clocks the port; any rate from 1 Hz up to a quarter of the system clock works.
    tick         = ctrl_r.clk_ext ? (ext_clk_s && !ext_prev_r) : int_tick;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      div_r      <= 8'h00;
      ext_prev_r <= 1'b0;
    end else begin
      div_r      <= div_nxt;
      ext_prev_r <= ext_prev_nxt;
    end
  end

  // ==========================================================================
  // Sequencer and readout intake
  logic [DPL_PORT_W-1:0] seq_r;
  logic [DPL_PORT_W-1:0] seq_nxt;
  logic                  pend_r;
  logic                  pend_nxt;
  logic [DPL_RES_W-1:0]  pend_data_r;
  logic [DPL_RES_W-1:0]  pend_data_nxt;
  logic                  stb_r;
  logic                  stb_nxt;
  logic                  live_r;
  logic                  live_nxt;
  logic                  sticky_r;
  logic                  sticky_nxt;
  logic                  res_mode;
  logic                  send;
  logic                  ovf_ev;

  // One result is held at a time, trading depth for a short, bounded delay.
  always_comb begin
    res_mode      = result_src(ctrl_r.src);
    send          = tick && pend_r && res_mode;
    // A result that finds the holder still full is a readout too fast.
    ovf_ev        = res_mode && res_in.valid && pend_r && !send;
    seq_nxt       = seq_cmd.valid ? seq_cmd.data : seq_r;
    pend_nxt      = pend_r;
    pend_data_nxt = pend_data_r;
    stb_nxt       = send ? !stb_r : stb_r;
    if (!res_mode) begin
      pend_nxt = 1'b0;
    end else if (res_in.valid && (!pend_r || send)) begin
      pend_nxt      = 1'b1;
      pend_data_nxt = res_in.data;
    end else if (send) begin
      pend_nxt = 1'b0;
    end
    // The live flag drops once the held word has gone out.
    live_nxt   = ovf_ev || (live_r && !send && res_mode);
    // A fresh overflow wins over a clear in the same cycle.
    sticky_nxt = ovf_ev ||
                 (sticky_r && !(wr_status && reg_wdata[DPL_STAT_STICKY_BIT]));
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      seq_r       <= '0;
      pend_r      <= 1'b0;
      pend_data_r <= '0;
      stb_r       <= 1'b0;
      live_r      <= 1'b0;
      sticky_r    <= 1'b0;
    end else begin
      seq_r       <= seq_nxt;
      pend_r      <= pend_nxt;
      pend_data_r <= pend_data_nxt;
      stb_r       <= stb_nxt;
      live_r      <= live_nxt;
      sticky_r    <= sticky_nxt;
    end
  end

  // ==========================================================================
  // Port drive
  logic [DPL_PORT_W-1:0] res_word;
  logic [DPL_PORT_W-1:0] out_nxt;
  logic [DPL_PORT_W-1:0] oe_nxt;
  logic [DPL_PORT_W-1:0] in_cap_r;
  logic [DPL_PORT_W-1:0] in_cap_nxt;
  logic                  in_ev;

  dpl_fmt u_fmt (
    .alt  (ctrl_r.src == DPL_SRC_ALT),
    .res  (pend_data_r),
    .stb  (!stb_r),
    .word (res_word)
  );

  // In the result modes the port keeps its last word between sends.
  always_comb begin
    out_nxt = port_out;
    if (tick) begin
      unique case (ctrl_r.src)
        DPL_SRC_MANUAL: out_nxt = out_val_r;
        DPL_SRC_SEQ:    out_nxt = seq_r;
        DPL_SRC_RES:    out_nxt = send ? res_word : port_out;
        DPL_SRC_ALT:    out_nxt = send ? res_word : port_out;
      endcase
    end
    in_cap_nxt = tick ? in_s : in_cap_r;
    in_ev      = tick && (((in_s ^ in_cap_r) & ~port_oe) != '0);
  end

  // Each lane's enable covers its eight pins as one unit.
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      assign oe_nxt[g*LANE_W +: LANE_W] = {LANE_W{drive_r[g]}};
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      port_out <= '0;
      port_oe  <= '0;
      in_cap_r <= '0;
    end else begin
      port_out <= out_nxt;
      port_oe  <= oe_nxt;
      in_cap_r <= in_cap_nxt;
    end
  end

  // ==========================================================================
  // Interrupts and read data
  // Clear-on-read loses nothing: an event in the read cycle sets the bit again.
  logic [DPL_IRQ_W-1:0] ist_r;
  logic [DPL_IRQ_W-1:0] ist_nxt;
  logic [DPL_IRQ_W-1:0] ev;
  logic                 irq_nxt;
  logic [31:0]          rdata_nxt;

  always_comb begin
    ev                  = '0;
    ev[DPL_IRQ_OVF_BIT] = ovf_ev;
    ev[DPL_IRQ_IN_BIT]  = in_ev;
    ist_nxt             = (rd_irq_stat ? '0 : ist_r) | ev;
    irq_nxt             = (ist_nxt & mask_nxt) != '0;
    // Read data is zero outside the read slot, so several slaves may be ORed.
    rdata_nxt           = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        DPL_REG_CTRL: begin
          rdata_nxt[DPL_CTRL_SRC_LSB +: 2] = ctrl_r.src;
          rdata_nxt[DPL_CTRL_CLK_BIT]      = ctrl_r.clk_ext;
        end
        DPL_REG_DRIVE:    rdata_nxt[LANES-1:0] = drive_r;
        DPL_REG_OUT:      rdata_nxt = out_val_r;
        DPL_REG_IN:       rdata_nxt = in_cap_r;
        DPL_REG_STATUS: begin
          rdata_nxt[DPL_STAT_LIVE_BIT]   = live_r;
          rdata_nxt[DPL_STAT_STICKY_BIT] = sticky_r;
        end
        DPL_REG_IRQ_STAT: rdata_nxt[DPL_IRQ_W-1:0] = ist_r;
        DPL_REG_IRQ_MASK: rdata_nxt[DPL_IRQ_W-1:0] = mask_r;
        default:          rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ist_r     <= '0;
      irq       <= 1'b0;
      reg_rdata <= 32'h0000_0000;
    end else begin
      ist_r     <= ist_nxt;
      irq       <= irq_nxt;
      reg_rdata <= rdata_nxt;
    end
  end

endmodule

// ---- sim/dpl_port_ctrl_properties.sv ----
`timescale 1ns/1ns
module dpl_port_ctrl_properties import dpl_pkg::*; (
  input wire logic                  clock,
  input wire logic                  rst_n,
  input wire logic [DPL_ADDR_W-1:0] reg_addr,
  input wire logic [31:0]           reg_wdata,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [31:0]           reg_rdata,
  input wire dpl_word_t             seq_cmd,
  input wire dpl_res_t              res_in,
  input wire logic [DPL_PORT_W-1:0] port_out,
  input wire logic [DPL_PORT_W-1:0] port_oe
);
  // ==========
  // Shadow state
  logic        wr_rw;
  logic        rd_unm;
  logic [31:0] wexp;
  logic [31:0] wexp_r;
  logic [31:0] oe_r;
  logic [31:0] seq_r;
  logic [7:0]  waddr_r;
  logic [2:0]  mode_r;
  logic [15:0] res_r;
  always_comb begin
    wr_rw = reg_wr;
    case (reg_addr)
      DPL_REG_CTRL:     wexp = {29'h0, reg_wdata[2:0]};
      DPL_REG_DRIVE:    wexp = {28'h0, reg_wdata[3:0]};
      DPL_REG_OUT:      wexp = reg_wdata;
      DPL_REG_IRQ_MASK: wexp = {30'h0, reg_wdata[1:0]};
      default: begin
        wexp = 32'h0;
        wr_rw = 1'b0;
      end
    endcase
    rd_unm = reg_rd && !(reg_addr inside {DPL_REG_CTRL, DPL_REG_DRIVE, DPL_REG_OUT,
      DPL_REG_IN, DPL_REG_STATUS, DPL_REG_IRQ_STAT, DPL_REG_IRQ_MASK});
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mode_r <= 3'h0;
      oe_r <= 32'h0;
    end else if (wr_rw) begin
      wexp_r <= wexp;
      waddr_r <= reg_addr;
      if (reg_addr == DPL_REG_CTRL) mode_r <= wexp[2:0];
      if (reg_addr == DPL_REG_DRIVE) oe_r <= {{8{wexp[3]}}, {8{wexp[2]}}, {8{wexp[1]}}, {8{wexp[0]}}};
    end
    if (seq_cmd.valid) seq_r <= seq_cmd.data;
    if (res_in.valid) res_r <= res_in.data;
  end
  // ==========
  // Properties
  a_oe_follow: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_rw && reg_addr == DPL_REG_DRIVE) ##1 !reg_wr |-> ##1 port_oe == oe_r)
    else $error("lane enables do not follow the drive register");
  a_rdata_idle: assert property (@(posedge clock) disable iff (!rst_n)
    !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data outside read slot");
  a_unmapped_rd: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rd_unm) |-> reg_rdata == 32'h0) else $error("unmapped read not zero");
  a_reg_readback: assert property (@(posedge clock) disable iff (!rst_n)
    wr_rw ##1 (reg_rd && reg_addr == waddr_r) |=> reg_rdata == wexp_r)
    else $error("register readback differs from write");
  a_manual_out: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_rw && reg_addr == DPL_REG_OUT && mode_r == 3'h0) ##1 !reg_wr |-> ##1 port_out == wexp_r)
    else $error("manual value not on port");
  a_seq_out: assert property (@(posedge clock) disable iff (!rst_n)
    (seq_cmd.valid && mode_r == 3'h1) ##1 !(seq_cmd.valid || reg_wr) |-> ##1 port_out == seq_r)
    else $error("sequencer value not on port");
  a_res_word: assert property (@(posedge clock) disable iff (!rst_n)
    (res_in.valid && mode_r == 3'h2) ##1 !(res_in.valid || reg_wr) |-> ##1 port_out[15:0] == res_r)
    else $error("result not on port");
  a_alt_word: assert property (@(posedge clock) disable iff (!rst_n)
    (res_in.valid && mode_r == 3'h3) ##1 !(res_in.valid || reg_wr) |-> ##1
    port_out[10:1] == res_r[9:0]) else $error("alternative result not on port");
endmodule
bind dpl_port_ctrl dpl_port_ctrl_properties u_props (.clock(clock), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .seq_cmd(seq_cmd), .res_in(res_in), .port_out(port_out),
  .port_oe(port_oe));

// ---- sim/dpl_far_model.sv ----
`timescale 1ns/1ns
module dpl_far_model import dpl_pkg::*; (
  input  wire logic [DPL_PORT_W-1:0] port_out,
  input  wire logic [DPL_PORT_W-1:0] port_oe,
  input  wire logic [DPL_PORT_W-1:0] far_val,
  input  wire logic                  ext_run,
  output logic      [DPL_PORT_W-1:0] port_in,
  output logic                       port_ext_clk
);
  // Each pin carries the port where its lane drives, else this equipment's level.
  always_comb port_in = (port_out & port_oe) | (far_val & ~port_oe);
  // The clock rests low between bursts; a 160 ns period stays below the ceiling.
  initial port_ext_clk = 1'b0;
  always #80 port_ext_clk = ext_run ? !port_ext_clk : 1'b0;
endmodule

// ---- sim/dpl_port_ctrl_tb.sv ----
`timescale 1ns/1ns
module dpl_port_ctrl_tb import dpl_pkg::*;;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        ext_run = 1'b0;
  logic        irq;
  logic        port_ext_clk;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] far_val = 32'h0;
  logic [31:0] reg_rdata, port_in, port_out, port_oe, d, v, p;
  logic [15:0] r;
  logic        stb_e = 1'b0;
  dpl_word_t   seq_cmd = '0;
  dpl_res_t    res_in = '0;
  int          n_fail = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          seed = 92;
  always #10 clock = ~clock;
  dpl_port_ctrl dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .seq_cmd(seq_cmd),
    .res_in(res_in), .port_in(port_in), .port_ext_clk(port_ext_clk), .port_out(port_out),
    .port_oe(port_oe), .irq(irq));
  dpl_far_model far (.port_out(port_out), .port_oe(port_oe), .far_val(far_val),
    .ext_run(ext_run), .port_in(port_in), .port_ext_clk(port_ext_clk));
  // ==========
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= x;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] x, output logic [31:0] y);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= x;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 y = reg_rdata;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 x = reg_rdata;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic send_res(input logic [15:0] x, input int n);
    @(posedge clock);
    res_in <= '{valid: 1'b1, data: x};
    repeat (n) @(posedge clock);
    res_in.valid <= 1'b0;
  endtask
  function automatic logic [31:0] oe_of(input logic [3:0] m);
    for (int i = 0; i < 4; i++) oe_of[8*i+:8] = {8{m[i]}};
  endfunction
  task automatic print_verdict();
    if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      print_verdict();
    end
  end
  // ==========
  // Scenarios
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    rd(DPL_REG_CTRL, d);
    chk(d, 32'h0);
    rd(DPL_REG_DRIVE, d);
    chk(d, 32'h0);
    rd(8'h1C, d);
    chk(d, 32'h0);
    for (int i = 0; i < 6; i++) begin
      p = (i == 0) ? 32'hF : (i == 1) ? 32'h0 : 32'($random(seed));
      far_val = $random(seed);
      v = $random(seed);
      wr_rd(DPL_REG_DRIVE, p, d);
      chk(d, {28'h0, p[3:0]});
      wr_rd(DPL_REG_OUT, v, d);
      chk(d, v);
      wait_cyc(6);
      chk(port_oe, oe_of(p[3:0]));
      chk(port_out, v);
      chk({31'h0, irq}, 32'h0);
      rd(DPL_REG_IN, d);
      chk(d, (v & oe_of(p[3:0])) | (far_val & ~oe_of(p[3:0])));
      if (i == 1) begin
        rd(DPL_REG_IRQ_STAT, d);
        far_val = ~far_val;
        wait_cyc(5);
        rd(DPL_REG_IRQ_STAT, d);
        chk(d, 32'h2);
      end
    end
    wr(DPL_REG_CTRL, 32'h1);
    for (int k = 0; k < 3; k++) begin
      v = $random(seed);
      @(posedge clock);
      seq_cmd <= '{valid: 1'b1, data: v};
      @(posedge clock);
      seq_cmd.valid <= 1'b0;
      wr(DPL_REG_OUT, ~v);
      wait_cyc(3);
      chk(port_out, v);
    end
    for (int m = 2; m < 4; m++) begin
      wr(DPL_REG_CTRL, m);
      for (int k = 0; k < 3; k++) begin
        r = $random(seed);
        send_res(r, 1);
        stb_e = ~stb_e;
        wait_cyc(4);
        if (m == 2) chk({15'h0, port_out[16:0]}, {15'h0, stb_e, r});
        else chk({21'h0, port_out[10:0]}, {21'h0, r[9:0], stb_e});
      end
    end
    wr(DPL_REG_IRQ_MASK, 32'h1);
    wr(DPL_REG_CTRL, 32'h6);
    for (int j = 0; j < 2; j++) begin
      rd(DPL_REG_IRQ_STAT, d);
      p = port_out;
      r = $random(seed);
      send_res(r, 2);
      wait_cyc(4);
      chk({31'h0, irq}, 32'h1);
      chk(port_out, p);
      rd(DPL_REG_STATUS, d);
      chk(d, 32'h3);
      ext_run = 1'b1;
      wait_cyc(40);
      ext_run = 1'b0;
      wait_cyc(10);
      chk({16'h0, port_out[15:0]}, {16'h0, r});
      rd(DPL_REG_STATUS, d);
      chk(d, 32'h2);
      rd(DPL_REG_IRQ_STAT, d);
      chk(d & 32'h1, 32'h1);
      rd(DPL_REG_IRQ_STAT, d);
      chk(d & 32'h1, 32'h0);
      wait_cyc(2);
      chk({31'h0, irq}, 32'h0);
      wr(DPL_REG_STATUS, 32'h2);
      rd(DPL_REG_STATUS, d);
      chk(d, 32'h0);
    end
    print_verdict();
  end
endmodule
